// ==== shared/dsdd_pkg.sv ====
// package: field layout and constants for the drive strength descriptor words
package dsdd_pkg;
  // ****************************************
  // field positions, first descriptor word
  // ****************************************
  localparam int unsigned DSDD_W = 32;
  localparam int unsigned DSDD_CNT_HI = 31;
  localparam int unsigned DSDD_CNT_LO = 30;
  localparam int unsigned DSDD_RSVD_BIT = 29;
  localparam int unsigned DSDD_ADDR_MODE_BIT = 28;
  localparam int unsigned DSDD_BYTE_SEL_BIT = 27;
  localparam int unsigned DSDD_LSB_HI = 26;
  localparam int unsigned DSDD_LSB_LO = 24;
  localparam int unsigned DSDD_LADDR_HI = 23;
  localparam int unsigned DSDD_LADDR_LO = 16;
  localparam int unsigned DSDD_OCT_DTR_BIT = 23;
  localparam int unsigned DSDD_OCT_STR_BIT = 22;
  localparam int unsigned DSDD_QUAD_DTR_BIT = 21;
  localparam int unsigned DSDD_QUAD_STR_BIT = 20;
  localparam int unsigned DSDD_DUMMY_HI = 19;
  localparam int unsigned DSDD_DUMMY_LO = 16;
  localparam int unsigned DSDD_OPC_HI = 15;
  localparam int unsigned DSDD_OPC_LO = 8;
  // ****************************************
  // field positions, second descriptor word
  // ****************************************
  localparam int unsigned DSDD_NTYPES = 5;
  localparam int unsigned DSDD_PAT_W = 3;
  localparam int unsigned DSDD_PAT0_HI = 31;
  localparam int unsigned DSDD_RSVD2_HI = 16;
  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic [7:0] DSDD_OPC_NONE = 8'h00;
  localparam logic [31:0] DSDD_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] DSDD_CNT_NONE = 2'h0;
  localparam logic DSDD_RSVD_VAL = 1'h0;
  localparam logic [3:0] DSDD_DUMMY_SINGLE = 4'h0;
  typedef logic [DSDD_PAT_W-1:0] dsdd_pat_t;
  typedef dsdd_pat_t [DSDD_NTYPES-1:0] dsdd_pats_t;
endpackage

// ==== shared/dsdd_if.sv ====
// interface: descriptor word transfer from device end to host decoder
`timescale 1ns/1ps
`default_nettype none
interface dsdd_if;
  logic word_valid;
  logic word_sel;
  logic [31:0] word_data;
  modport dev (output word_valid, output word_sel, output word_data);
  modport host (input word_valid, input word_sel, input word_data);
endinterface // dsdd_if
`default_nettype wire

// ==== hw/dsdd_device.sv ====
// design: device end that assembles and presents both descriptor words
`timescale 1ns/1ps
`default_nettype none
module dsdd_device (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] cfg_bit_count,
  input wire logic cfg_addr_mode,
  input wire logic cfg_byte1_sel,
  input wire logic [2:0] cfg_lsb_pos,
  input wire logic [7:0] cfg_local_addr,
  input wire logic [3:0] cfg_mode_flags,
  input wire logic [3:0] cfg_dummy,
  input wire logic [7:0] cfg_read_opcode,
  input wire dsdd_pkg::dsdd_pats_t cfg_patterns,
  input wire logic send_req,
  output logic send_busy,
  dsdd_if.dev link
);
  import dsdd_pkg::*;

  typedef struct packed {
    logic valid;
    logic sel;
    logic busy;
    logic [31:0] data;
  } dsdd_dev_st_t;

  dsdd_dev_st_t st_r, st_nxt;
  logic [31:0] word1, word2;

  // ****************************************
  // descriptor word assembly
  // ****************************************
  // keep only the pattern bits the physical register really has
  function automatic dsdd_pat_t mask_pat(input dsdd_pat_t p, input logic [1:0] n);
    dsdd_pat_t m;
    m = 3'h0;
    case (n)
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
      default: m = 3'h0;
    endcase
    return p & m;
  endfunction

  // fields are laid out from the configuration; bits 23:16 of word one
  // hold either the address or the mode set, never both
  always_comb begin
    word1 = DSDD_WORD_RST;
    word1[DSDD_CNT_HI:DSDD_CNT_LO] = cfg_bit_count;
    word1[DSDD_RSVD_BIT] = DSDD_RSVD_VAL;
    word1[DSDD_ADDR_MODE_BIT] = cfg_addr_mode;
    word1[DSDD_BYTE_SEL_BIT] = cfg_byte1_sel;
    word1[DSDD_LSB_HI:DSDD_LSB_LO] = cfg_lsb_pos;
    if (cfg_addr_mode) begin
      word1[DSDD_LADDR_HI:DSDD_LADDR_LO] = cfg_local_addr;
    end else begin
      word1[DSDD_OCT_DTR_BIT] = cfg_mode_flags[3];
      word1[DSDD_OCT_STR_BIT] = cfg_mode_flags[2];
      word1[DSDD_QUAD_DTR_BIT] = cfg_mode_flags[1];
      word1[DSDD_QUAD_STR_BIT] = cfg_mode_flags[0];
      word1[DSDD_DUMMY_HI:DSDD_DUMMY_LO] = cfg_dummy;
    end
    word1[DSDD_OPC_HI:DSDD_OPC_LO] = cfg_read_opcode;
    word2 = DSDD_WORD_RST;
    for (int i = 0; i < DSDD_NTYPES; i++) begin
      word2[DSDD_PAT0_HI - i*DSDD_PAT_W -: DSDD_PAT_W] =
        mask_pat(cfg_patterns[i], cfg_bit_count);
    end
  end

  // ****************************************
  // two-beat transfer: word one then word two
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    if (st_r.busy) begin
      st_nxt.valid = 1'b1;
      st_nxt.sel = 1'b1;
      st_nxt.data = word2;
      st_nxt.busy = 1'b0;
    end else if (send_req && !st_r.valid) begin
      // word two still on the wire keeps send_busy high, so a request is only taken here once valid has dropped
      st_nxt.valid = 1'b1;
      st_nxt.sel = 1'b0;
      st_nxt.data = word1;
      st_nxt.busy = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.word_valid = st_r.valid;
  assign link.word_sel = st_r.sel;
  assign link.word_data = st_r.data;
  assign send_busy = st_r.busy | st_r.valid; // requests ignored while set
endmodule // dsdd_device
`default_nettype wire

// ==== hw/dsdd_host.sv ====
// design: host decoder that captures and splits both descriptor words
`timescale 1ns/1ps
`default_nettype none
module dsdd_host (
  input wire logic clock,
  input wire logic sys_rst,
  dsdd_if.host link,
  output logic ctl_avail,
  output logic [1:0] ctl_bit_count,
  output logic addr_access,
  output logic byte1_sel,
  output logic [2:0] lsb_pos,
  output logic [7:0] local_addr,
  output logic oct_dtr_ok,
  output logic oct_str_ok,
  output logic quad_dtr_ok,
  output logic quad_str_ok,
  output logic [3:0] multi_dummy,
  output logic [3:0] single_dummy,
  output logic [7:0] read_opcode,
  output logic read_allowed,
  output dsdd_pkg::dsdd_pats_t driver_patterns,
  output logic words_loaded
);
  import dsdd_pkg::*;

  typedef struct packed {
    logic [31:0] w1;
    logic [31:0] w2;
    logic [1:0] got;
  } dsdd_host_st_t;

  dsdd_host_st_t st_r, st_nxt;

  // ****************************************
  // capture on valid strobe
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (link.word_valid) begin
      if (link.word_sel) begin
        st_nxt.w2 = link.word_data;
        st_nxt.got[1] = 1'b1;
      end else begin
        st_nxt.w1 = link.word_data;
        st_nxt.got[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // field decode straight from captured flops
  // ****************************************
  // a zero mode flag only rules out this dummy count, so it is exported
  // as a per-count flag and never as "mode absent"
  always_comb begin
    ctl_bit_count = st_r.w1[DSDD_CNT_HI:DSDD_CNT_LO];
    ctl_avail = ctl_bit_count != DSDD_CNT_NONE;
    addr_access = st_r.w1[DSDD_ADDR_MODE_BIT];
    byte1_sel = st_r.w1[DSDD_BYTE_SEL_BIT];
    lsb_pos = st_r.w1[DSDD_LSB_HI:DSDD_LSB_LO];
    local_addr = addr_access ? st_r.w1[DSDD_LADDR_HI:DSDD_LADDR_LO] : 8'h00;
    oct_dtr_ok = ~addr_access & st_r.w1[DSDD_OCT_DTR_BIT];
    oct_str_ok = ~addr_access & st_r.w1[DSDD_OCT_STR_BIT];
    quad_dtr_ok = ~addr_access & st_r.w1[DSDD_QUAD_DTR_BIT];
    quad_str_ok = ~addr_access & st_r.w1[DSDD_QUAD_STR_BIT];
    multi_dummy = addr_access ? 4'h0 : st_r.w1[DSDD_DUMMY_HI:DSDD_DUMMY_LO];
    single_dummy = DSDD_DUMMY_SINGLE;
    read_opcode = st_r.w1[DSDD_OPC_HI:DSDD_OPC_LO];
    read_allowed = st_r.got[0] & (read_opcode != DSDD_OPC_NONE);
    for (int i = 0; i < DSDD_NTYPES; i++) begin
      // upper bits beyond the control count are dropped; 16:0 never read
      driver_patterns[i] = st_r.w2[DSDD_PAT0_HI - i*DSDD_PAT_W -: DSDD_PAT_W] &
        ((3'h1 << ctl_bit_count) - 3'h1);
    end
    words_loaded = &st_r.got;
  end
endmodule // dsdd_host
`default_nettype wire

// ==== dv/dsdd_checker.sv ====
// checker: wire-level properties of the descriptor word link
`timescale 1ns/1ps
`default_nettype none
module dsdd_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic word_valid,
  input wire logic word_sel,
  input wire logic [31:0] word_data
);
  // ********
  // link properties
  // ********
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic w1 = word_valid && !word_sel;
  wire logic w2 = word_valid && word_sel;
  property p_w2_rsvd; w2 |-> word_data[16:0] == 17'h0; endproperty
  a_w2_rsvd: assert property (p_w2_rsvd) else $error("word two low bits set");
  property p_w1_rsvd; w1 |-> !word_data[29]; endproperty
  a_w1_rsvd: assert property (p_w1_rsvd) else $error("word one bit 29 set");
  property p_pair; w1 |=> w2; endproperty
  a_pair: assert property (p_pair) else $error("word two did not follow");
  property p_after; w2 |=> !word_valid; endproperty
  a_after: assert property (p_after) else $error("extra word after pair");
  // one control bit: upper two bits of each pattern must be clear
  property p_mask1; w1 && word_data[31:30] == 2'h1 |=> (word_data & 32'hDB6C_0000) == 32'h0;
  endproperty
  a_mask1: assert property (p_mask1) else $error("one-bit pattern has upper bits");
  property p_mask2; w1 && word_data[31:30] == 2'h2 |=> (word_data & 32'h9248_0000) == 32'h0;
  endproperty
  a_mask2: assert property (p_mask2) else $error("two-bit pattern has top bit");
  property p_rst; disable iff (1'b0) sys_rst |=> !word_valid; endproperty
  a_rst: assert property (p_rst) else $error("valid after reset");
  // guard on past reset: data may jump when reset clears it
  property p_hold; !word_valid && !$past(sys_rst) |-> $stable(word_data); endproperty
  a_hold: assert property (p_hold) else $error("data moved while idle");
  c_addr: cover property (w1 && word_data[28]);
  c_direct: cover property (w1 && !word_data[28]);
  c_cnt3: cover property (w1 && word_data[31:30] == 2'h3);
endmodule // dsdd_checker
`default_nettype wire

// ==== dv/drive_strength_descriptor_decode_test.sv ====
// testbench: both ends joined, random descriptors, queued expectations
`timescale 1ns/1ps
`default_nettype none
module drive_strength_descriptor_decode_test;
  import dsdd_pkg::*;
  // ********
  // stimulus and checking
  // ********
  logic clock = 0, sys_rst = 1, send_req = 0, cfg_addr_mode = 0, cfg_byte1_sel = 0;
  logic [1:0] cfg_bit_count = 0;
  logic [2:0] cfg_lsb_pos = 0;
  logic [3:0] cfg_mode_flags = 0, cfg_dummy = 0;
  logic [7:0] cfg_local_addr = 0, cfg_read_opcode = 0;
  dsdd_pats_t cfg_patterns = '0;
  wire logic send_busy;
  wire logic [52:0] got;
  logic [52:0] q_host[$];
  logic [31:0] q_w2[$];
  int n_fail = 0, checked = 0;
  dsdd_if dl();
  dsdd_device dsdd_device_i(.clock(clock), .sys_rst(sys_rst), .cfg_bit_count(cfg_bit_count),
    .cfg_addr_mode(cfg_addr_mode), .cfg_byte1_sel(cfg_byte1_sel), .cfg_lsb_pos(cfg_lsb_pos),
    .cfg_local_addr(cfg_local_addr), .cfg_mode_flags(cfg_mode_flags), .cfg_dummy(cfg_dummy),
    .cfg_read_opcode(cfg_read_opcode), .cfg_patterns(cfg_patterns), .send_req(send_req),
    .send_busy(send_busy), .link(dl));
  dsdd_host dsdd_host_i(.clock(clock), .sys_rst(sys_rst), .link(dl), .ctl_avail(got[52]),
    .ctl_bit_count(got[51:50]), .addr_access(got[49]), .byte1_sel(got[48]), .lsb_pos(got[47:45]),
    .local_addr(got[44:37]), .oct_dtr_ok(got[36]), .oct_str_ok(got[35]), .quad_dtr_ok(got[34]),
    .quad_str_ok(got[33]), .multi_dummy(got[32:29]), .single_dummy(got[28:25]),
    .read_opcode(got[24:17]), .read_allowed(got[16]), .driver_patterns(got[15:1]),
    .words_loaded(got[0]));
  dsdd_checker dsdd_checker_i(.clock(clock), .sys_rst(sys_rst), .word_valid(dl.word_valid),
    .word_sel(dl.word_sel), .word_data(dl.word_data));
  initial forever #2 clock = ~clock;
  task automatic cmp_host(input logic [52:0] g, input logic [52:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: fields %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: word two %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: busy %b want %b", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    // a promised pair that never reached the wire is a failure too
    if (q_w2.size() != 0 || q_host.size() != 0) n_fail++;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // expectations noted first, then one request; hold keeps it up while busy
  // so the refused window is exercised; busy wait is bounded
  task automatic send_one(input logic hold);
    dsdd_pats_t mp;
    int n;
    mp = cfg_patterns & {5{3'(4'h1 << cfg_bit_count) - 3'h1}};
    q_host.push_back({cfg_bit_count != 2'h0, cfg_bit_count, cfg_addr_mode, cfg_byte1_sel,
      cfg_lsb_pos, cfg_addr_mode ? cfg_local_addr : 8'h00,
      cfg_addr_mode ? 8'h00 : {cfg_mode_flags, cfg_dummy}, DSDD_DUMMY_SINGLE,
      cfg_read_opcode, cfg_read_opcode != DSDD_OPC_NONE, mp, 1'b1});
    q_w2.push_back({mp[0], mp[1], mp[2], mp[3], mp[4], 17'h0});
    send_req = 1;
    @(negedge clock) send_req = hold;
    cmp_bit(send_busy, 1'b1);
    n = 0;
    while (send_busy !== 1'b0 && n < 20) begin
      @(negedge clock);
      n++;
    end
    send_req = 0;
    if (send_busy !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
    repeat (2) @(negedge clock);
  endtask
  // monitor: word two on the wire, then the decoded fields two edges on
  always @(posedge clock) begin
    if (dl.word_valid === 1'b1 && dl.word_sel === 1'b1) begin
      if (q_w2.size() == 0 || q_host.size() == 0) begin
        n_fail++;
        $display("unexpected at %0t: word two with nothing expected", $time);
      end else begin
        cmp_word(dl.word_data, q_w2.pop_front());
        @(posedge clock);
        @(negedge clock);
        cmp_host(got, q_host.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(32'hF24CF6CF));
    repeat (20) @(negedge clock);
    sys_rst = 0;
    for (int i = 0; i < 40; i++) begin
      cfg_bit_count = 2'(i);
      cfg_addr_mode = i[2];
      cfg_byte1_sel = 1'($urandom);
      cfg_lsb_pos = 3'($urandom);
      cfg_local_addr = 8'($urandom);
      cfg_mode_flags = 4'($urandom);
      cfg_dummy = 4'($urandom);
      cfg_read_opcode = (i % 5 == 0) ? 8'h00 : 8'($urandom);
      cfg_patterns = 15'($urandom);
      send_one(i[0]);
    end
    $display("test random_descriptors done");
    sys_rst = 1;
    repeat (2) @(negedge clock);
    cmp_host(got, 53'h0);
    sys_rst = 0;
    // first request right at release, then the decoder must refill
    send_one(1'b0);
    $display("test mid_run_reset done");
    report_and_stop();
  end
endmodule // drive_strength_descriptor_decode_test
`default_nettype wire
